// >>> rtl/slq_pkg.sv
package slq_pkg;

  // ==========================================================================
  // command and reply layout
  // ==========================================================================
  localparam logic [7:0] CMD_GET_LISTS   = 8'h30;
  localparam int         REPLY_LEN       = 32;
  localparam logic [4:0] LAST_IDX        = 5'h1F;
  localparam logic [4:0] FIRST_IDX       = 5'h00;
  localparam int         OFS_ACTIVE      = 0;
  localparam int         OFS_DETECTED    = 8;
  localparam int         OFS_PERMANENT   = 16;
  localparam int         OFS_FLAG1       = 24;
  localparam int         OFS_FLAG2       = 25;
  localparam int         BITMAP_BYTES    = 24;
  localparam int         LIST_BYTES      = 8;
  localparam logic [7:0] RESERVED_BYTE   = 8'h00;

  // ==========================================================================
  // first flag byte bit positions
  // ==========================================================================
  localparam int F1_OFFLINE_READY = 0;
  localparam int F1_POWER_FAIL    = 1;
  localparam int F1_NORMAL_MODE   = 2;
  localparam int F1_CONFIG_MODE   = 3;
  localparam int F1_AUTO_POSSIBLE = 4;
  localparam int F1_AUTO_ALLOWED  = 5;
  localparam int F1_ZERO_ADDR     = 6;
  localparam int F1_CONFIG_MATCH  = 7;

  // ==========================================================================
  // second flag byte bit positions
  // ==========================================================================
  localparam int F2_OFFLINE       = 0;
  localparam int F2_INTERNAL      = 1;
  localparam int F2_NVM_OK        = 2;
  localparam int F2_AUTO_ENABLED  = 3;
  localparam int F2_IO_FAULT      = 4;
  localparam int F2_GROUND_SHORT  = 5;
  localparam int F2_RESERVED      = 6;
  localparam int F2_POWER_ON_SEEN = 7;

  // ==========================================================================
  // carriers
  // ==========================================================================
  // list bit n is single slave n (0..31), bit 32+n is B-type slave nB
  typedef struct packed {
    logic [63:0] active_slave_list;
    logic [63:0] detected_slave_list;
    logic [63:0] permanent_slave_list;
  } slq_lists_s;

  typedef struct packed {
    logic offline_ready;
    logic cable_power_fail;
    logic normal_mode;
    logic config_mode;
    logic autoassign_possible;
    logic autoassign_allowed;
    logic offline;
    logic nvm_test_ok;
    logic autoassign_enabled;
    logic attached_io_fault;
    logic ground_short;
    logic power_on_start_seen;
  } slq_status_s;

  typedef struct packed {
    slq_lists_s lists;
    logic [7:0] flag1;
    logic [7:0] flag2;
  } slq_snap_s;

  typedef enum logic [1:0] {
    SLQ_IDLE,
    SLQ_LOAD,
    SLQ_SEND
  } slq_phase_e;

  typedef struct packed {
    slq_phase_e phase;
    logic [4:0] idx;
    slq_snap_s  snap;
    logic [7:0] rsp_byte;
  } slq_state_s;

  localparam slq_state_s STATE_RESET = '{phase: SLQ_IDLE, idx: 5'h00, snap: '0, rsp_byte: 8'h00};

endpackage

// >>> rtl/slq_byte_pick.sv
`timescale 1ns/1ps
module slq_byte_pick (
  input  slq_pkg::slq_snap_s snap,
  input  wire logic [4:0]    idx,
  output logic [7:0]         pick
);

  // ==========================================================================
  // reply image
  // ==========================================================================
  logic [7:0]   image [slq_pkg::REPLY_LEN];
  logic [191:0] bitmaps;

  assign bitmaps = {snap.lists.permanent_slave_list, snap.lists.detected_slave_list,
                    snap.lists.active_slave_list};

  for (genvar b = 0; b < slq_pkg::REPLY_LEN; b++) begin : g_byte
    if (b < slq_pkg::BITMAP_BYTES) begin : g_map
      // bit 7 carries the lowest address of the byte
      for (genvar j = 0; j < 8; j++) begin : g_bit
        assign image[b][7-j] = bitmaps[b*8+j];
      end
    end else if (b == slq_pkg::OFS_FLAG1) begin : g_f1
      assign image[b] = snap.flag1;
    end else if (b == slq_pkg::OFS_FLAG2) begin : g_f2
      assign image[b] = snap.flag2;
    end else begin : g_rsv
      assign image[b] = slq_pkg::RESERVED_BYTE;
    end
  end

  assign pick = image[idx];

endmodule

// >>> rtl/slq_list_query.sv
`timescale 1ns/1ps
module slq_list_query (
  input  wire logic          mclk,
  input  wire logic          resetn,
  input  wire logic          req_valid,
  output logic               req_ready,
  input  wire logic [7:0]    req_byte,
  input  slq_pkg::slq_lists_s  lists,
  input  slq_pkg::slq_status_s status,
  output logic               rsp_valid,
  input  wire logic          rsp_ready,
  output logic [7:0]         rsp_byte,
  output logic               rsp_last,
  output logic               cmd_unknown
);

  // ==========================================================================
  // state
  // ==========================================================================
  slq_pkg::slq_state_s state_q;
  slq_pkg::slq_state_s state_d;
  logic [7:0]          flag1_now;
  logic [7:0]          flag2_now;
  logic [7:0]          picked;
  logic [4:0]          pick_idx;
  logic                req_take;
  logic                rsp_take;

  // ==========================================================================
  // live flag bytes
  // ==========================================================================
  always_comb begin
    flag1_now                             = 8'h00;
    flag1_now[slq_pkg::F1_OFFLINE_READY] = status.offline_ready;
    flag1_now[slq_pkg::F1_POWER_FAIL]    = status.cable_power_fail;
    flag1_now[slq_pkg::F1_NORMAL_MODE]   = status.normal_mode;
    flag1_now[slq_pkg::F1_CONFIG_MODE]   = status.config_mode;
    flag1_now[slq_pkg::F1_AUTO_POSSIBLE] = status.autoassign_possible;
    flag1_now[slq_pkg::F1_AUTO_ALLOWED]  = status.autoassign_allowed;
    flag1_now[slq_pkg::F1_ZERO_ADDR]     = lists.detected_slave_list[0];
    flag1_now[slq_pkg::F1_CONFIG_MATCH]  =
      (lists.permanent_slave_list == lists.detected_slave_list);
    flag2_now                             = 8'h00;
    flag2_now[slq_pkg::F2_OFFLINE]       = status.offline;
    flag2_now[slq_pkg::F2_INTERNAL]      = 1'b1;
    flag2_now[slq_pkg::F2_NVM_OK]        = status.nvm_test_ok;
    flag2_now[slq_pkg::F2_AUTO_ENABLED]  = status.autoassign_enabled;
    flag2_now[slq_pkg::F2_IO_FAULT]      = status.attached_io_fault;
    flag2_now[slq_pkg::F2_GROUND_SHORT]  = status.ground_short;
    flag2_now[slq_pkg::F2_RESERVED]      = 1'b0;
    flag2_now[slq_pkg::F2_POWER_ON_SEEN] = status.power_on_start_seen;
  end

  // ==========================================================================
  // reply byte selection
  // ==========================================================================
  // next byte is fetched ahead so the data output stays a flop
  assign pick_idx = (state_q.phase == slq_pkg::SLQ_LOAD) ? state_q.idx : 5'(state_q.idx + 5'h01);

  slq_byte_pick u_pick (
    .snap (state_q.snap),
    .idx  (pick_idx),
    .pick (picked)
  );

  // ==========================================================================
  // handshakes
  // ==========================================================================
  assign req_ready = (state_q.phase == slq_pkg::SLQ_IDLE);
  assign req_take  = req_valid && req_ready;
  assign rsp_valid = (state_q.phase == slq_pkg::SLQ_SEND);
  assign rsp_take  = rsp_valid && rsp_ready;
  assign rsp_byte  = state_q.rsp_byte;
  assign rsp_last  = rsp_valid && (state_q.idx == slq_pkg::LAST_IDX);

  // unknown codes are swallowed; this block serves one command only
  assign cmd_unknown = req_take && (req_byte != slq_pkg::CMD_GET_LISTS);

  // ==========================================================================
  // sequencer
  // ==========================================================================
  always_comb begin
    state_d = state_q;
    case (state_q.phase)
      slq_pkg::SLQ_IDLE: begin
        if (req_take && req_byte == slq_pkg::CMD_GET_LISTS) begin
          // snapshot keeps the reply coherent while the master drains it
          state_d.snap.lists = lists;
          state_d.snap.flag1 = flag1_now;
          state_d.snap.flag2 = flag2_now;
          state_d.idx        = slq_pkg::FIRST_IDX;
          state_d.phase      = slq_pkg::SLQ_LOAD;
        end
      end
      slq_pkg::SLQ_LOAD: begin
        state_d.rsp_byte = picked;
        state_d.phase    = slq_pkg::SLQ_SEND;
      end
      slq_pkg::SLQ_SEND: begin
        if (rsp_take) begin
          if (state_q.idx == slq_pkg::LAST_IDX) begin
            state_d.phase = slq_pkg::SLQ_IDLE;
          end else begin
            state_d.idx      = 5'(state_q.idx + 5'h01);
            state_d.rsp_byte = picked;
          end
        end
      end
      default: begin
        state_d = slq_pkg::STATE_RESET;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= slq_pkg::STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

endmodule

// >>> bench/slq_assertions.sv
`timescale 1ns/1ps
module slq_chk (
  input wire logic            mclk,
  input wire logic            resetn,
  input wire logic            req_valid,
  input wire logic            req_ready,
  input wire logic [7:0]      req_byte,
  input slq_pkg::slq_lists_s  lists,
  input slq_pkg::slq_status_s status,
  input wire logic            rsp_valid,
  input wire logic            rsp_ready,
  input wire logic [7:0]      rsp_byte,
  input wire logic            rsp_last,
  input wire logic            cmd_unknown
);
  logic [4:0] pos_q;
  logic       take;
  assign take = req_valid && req_ready;
  // own byte counter, wraps to 0 after byte 31
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) pos_q <= 5'h00;
    else if (rsp_valid && rsp_ready) pos_q <= pos_q + 5'h01;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_busy_refuses: assert property (rsp_valid |-> !req_ready) else $error("request taken in reply");
  a_reply_starts: assert property (take && req_byte == 8'h30 |-> ##2 rsp_valid && pos_q == 5'h00)
    else $error("reply late");
  a_unknown_drop: assert property (take && req_byte != 8'h30 |-> cmd_unknown ##1 !rsp_valid ##1 !rsp_valid)
    else $error("unknown command answered");
  a_unknown_cause: assert property (cmd_unknown |-> take && req_byte != 8'h30) else $error("stray unknown");
  a_byte_holds: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_byte))
    else $error("byte dropped");
  a_last_pos: assert property (rsp_valid |-> rsp_last == (pos_q == 5'h1F)) else $error("last misplaced");
  a_end_idle: assert property (rsp_valid && rsp_last && rsp_ready |=> !rsp_valid && req_ready)
    else $error("no idle after reply");
  a_reserved_zero: assert property (rsp_valid && pos_q >= 5'h1A |-> rsp_byte == 8'h00)
    else $error("reserved byte set");
  a_flag2_fixed: assert property (rsp_valid && pos_q == 5'h19 |-> rsp_byte[1] && !rsp_byte[6])
    else $error("fixed flag bits wrong");
endmodule
bind slq_list_query slq_chk u_chk (.mclk(mclk), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready),
  .req_byte(req_byte), .lists(lists), .status(status), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
  .rsp_byte(rsp_byte), .rsp_last(rsp_last), .cmd_unknown(cmd_unknown));

// >>> bench/slq_master.sv
`timescale 1ns/1ps
module slq_master (
  input  wire logic       mclk,
  output logic            req_valid,
  input  wire logic       req_ready,
  output logic [7:0]      req_byte,
  input  wire logic       rsp_valid,
  output logic            rsp_ready,
  input  wire logic [7:0] rsp_byte,
  input  wire logic       cmd_unknown
);
  logic [7:0] got [0:31];
  logic       unk_seen;
  initial begin
    req_valid = 1'b0;
    req_byte  = 8'h00;
    rsp_ready = 1'b0;
  end
  // go gives the stall pattern; bit 0 set keeps the reply moving
  task automatic req(input logic [7:0] cmd, input logic [31:0] go);
    int n;
    int c;
    n = 0;
    c = 0;
    @(negedge mclk);
    req_valid = 1'b1;
    req_byte  = cmd;
    while (!req_ready) @(negedge mclk);
    #1 unk_seen = cmd_unknown;
    @(negedge mclk);
    req_valid = 1'b0;
    // released line never keeps its last value
    req_byte  = ~cmd;
    while (cmd == 8'h30 && n < 32) begin
      rsp_ready = go[c % 32];
      c++;
      if (rsp_valid && rsp_ready) begin
        got[n] = rsp_byte;
        n++;
      end
      @(negedge mclk);
    end
    rsp_ready = 1'b0;
  endtask
endmodule

// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  slq_pkg::slq_lists_s  lists;
  slq_pkg::slq_status_s status;
  logic                 mclk;
  logic                 resetn;
  logic                 req_valid;
  logic                 req_ready;
  logic [7:0]           req_byte;
  logic                 rsp_valid;
  logic                 rsp_ready;
  logic [7:0]           rsp_byte;
  logic                 rsp_last;
  logic                 cmd_unknown;
  logic [7:0]           exp_q [$];
  int                   seed;
  int                   error_cnt;
  int                   comparisons;
  slq_list_query u_dut (.mclk(mclk), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready),
    .req_byte(req_byte), .lists(lists), .status(status), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_byte(rsp_byte), .rsp_last(rsp_last), .cmd_unknown(cmd_unknown));
  slq_master u_mst (.mclk(mclk), .req_valid(req_valid), .req_ready(req_ready), .req_byte(req_byte),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_byte(rsp_byte), .cmd_unknown(cmd_unknown));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  function automatic logic [7:0] model_byte(int b);
    logic [63:0] l;
    logic [7:0]  r;
    l = (b < 8) ? lists.active_slave_list : (b < 16) ? lists.detected_slave_list : lists.permanent_slave_list;
    for (int j = 0; j < 8; j++) r[7 - j] = l[(b % 8) * 8 + j];
    if (b == 24) r = {lists.permanent_slave_list == lists.detected_slave_list, lists.detected_slave_list[0],
      status.autoassign_allowed, status.autoassign_possible, status.config_mode, status.normal_mode,
      status.cable_power_fail, status.offline_ready};
    if (b == 25) r = {status.power_on_start_seen, 1'b0, status.ground_short, status.attached_io_fault,
      status.autoassign_enabled, status.nvm_test_ok, 1'b1, status.offline};
    if (b > 25) r = 8'h00;
    return r;
  endfunction
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic shake();
    lists  = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
    status = slq_pkg::slq_status_s'(12'($random(seed)));
  endtask
  task automatic give_verdict();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #(5000 * 100);
    error_cnt++;
    give_verdict();
  end
  initial begin
    seed = 32'h4CCB;
    error_cnt = 0;
    comparisons = 0;
    resetn = 1'b0;
    shake();
    repeat (6) @(posedge mclk);
    @(negedge mclk) resetn = 1'b1;
    for (int t = 0; t < 12; t++) begin
      shake();
      if (t == 1) begin
        lists.detected_slave_list[0] = 1'b1;
        lists.permanent_slave_list   = lists.detected_slave_list;
      end
      if (t % 4 == 3) begin
        u_mst.req(8'h30 ^ (8'h01 << (t % 8)), 32'h0);
        chk("unknown flag", 8'h01, {7'h00, u_mst.unk_seen});
      end else begin
        for (int b = 0; b < 32; b++) exp_q.push_back(model_byte(b));
        // lists move mid-reply: the reply must stay a snapshot
        fork
          u_mst.req(8'h30, (t < 2) ? 32'hFFFFFFFF : ($random(seed) | 32'h1));
          begin
            repeat (5) @(negedge mclk);
            shake();
          end
        join
        chk("unknown flag", 8'h00, {7'h00, u_mst.unk_seen});
        for (int b = 0; b < 32; b++) chk("reply byte", exp_q.pop_front(), u_mst.got[b]);
      end
    end
    give_verdict();
  end
endmodule
